// ### logic/sfd_bpe_lut.sv
/*
 format code to bits_per_element lookup.
 assumes a 9-bit code; purely combinational, read by the decoder core.
*/
`timescale 1ns/1ps
module sfd_bpe_lut
	import sfd_pkg::*;
(
	input  wire logic [8:0] code_i,  // format code
	output logic      [8:0] bpe_o,   // bits per element
	output logic            known_o  // code listed in table
);
	// ----------------------------------------------------------------
	// table
	// ----------------------------------------------------------------
	// range groups; holes left unknown
	always_comb begin
		bpe_o   = 9'h000;
		known_o = 1'b1;
		case (code_i) inside
			[9'h000:9'h008], [9'h020:9'h021]: bpe_o = 9'h080;
			[9'h040:9'h046], 9'h050:          bpe_o = 9'h060;
			[9'h080:9'h096], [9'h0a0:9'h0a1]: bpe_o = 9'h040;
			[9'h0c0:9'h0c5], [9'h0c7:9'h0d3], [9'h0d6:9'h0da],
			[9'h0dd:9'h0ee], [9'h0f0:9'h0f9],
			[9'h1b2:9'h1bb]:                  bpe_o = 9'h020;
			[9'h100:9'h11f], [9'h122:9'h127]: bpe_o = 9'h010;
			[9'h140:9'h150], [9'h152:9'h155]: bpe_o = 9'h008;
			9'h181, 9'h18e:                   bpe_o = 9'h001;
			9'h184, 9'h185:                   bpe_o = 9'h002;
			[9'h193:9'h196], 9'h1a8, 9'h1c8, 9'h1c9: bpe_o = 9'h018;
			9'h197, 9'h1bc:                   bpe_o = 9'h100;
			9'h198, 9'h1bd:                   bpe_o = 9'h0c0;
			[9'h19b:9'h19f], 9'h1b0, 9'h1b1:  bpe_o = 9'h030;
			9'h180, 9'h182, 9'h183, [9'h186:9'h18d], [9'h18f:9'h192],
			9'h199, 9'h19a, [9'h1a1:9'h1a5], [9'h1a9:9'h1af],
			[9'h1c0:9'h1c3], 9'h1ff:          bpe_o = 9'h000;
			default:                          known_o = 1'b0;
		endcase
	end
endmodule

// ### logic/sfd_pkg.sv
/*
 surface descriptor decode package: register map, field positions, reset values, format codes.
 assumes a classic wishbone slave with 32-bit data and byte addresses.
*/
package sfd_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] SFD_OFF_WORD5   = 8'h00; // descriptor word with enables and offset
	localparam logic [7:0] SFD_OFF_WORD6   = 8'h04; // control surface / append address word
	localparam logic [7:0] SFD_OFF_WORD7   = 8'h08; // clear colours and min lod
	localparam logic [7:0] SFD_OFF_FORMAT  = 8'h0c; // format code and compression enable
	localparam logic [7:0] SFD_OFF_CTRL    = 8'h10; // surface kind control
	localparam logic [7:0] SFD_OFF_STATUS  = 8'h14; // decoded status
	localparam logic [7:0] SFD_OFF_ADDR    = 8'h18; // decoded side address
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SFD_BIT_CS_EN      = 0;  // control surface enable
	localparam int SFD_BIT_APPEND_EN  = 1;  // append counter enable
	localparam int SFD_CHROMA_MSB     = 13; // chroma row offset top bit
	localparam int SFD_CS_ADDR_LSB    = 12; // control surface base lsb
	localparam int SFD_APPEND_LSB     = 6;  // append counter address lsb
	localparam int SFD_BIT_CLR_R      = 31; // red clear select
	localparam int SFD_BIT_CLR_A      = 28; // alpha clear select
	localparam int SFD_LOD_MSB        = 11; // min lod top bit
	localparam int SFD_FMT_W          = 9;  // format code width
	localparam int SFD_BIT_ADAPT      = 9;  // compression enable in format reg
	localparam int SFD_BIT_TWO_PLANE  = 0;  // ctrl: two_plane_layout surface
	localparam int SFD_BIT_SAMPLED    = 1;  // ctrl: sampled surface
	localparam int SFD_BIT_RT         = 2;  // ctrl: render target
	localparam int SFD_BIT_MULTI      = 3;  // ctrl: multisampled
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] SFD_RST_WORD = 32'h0000_0000;
	localparam logic [8:0]  SFD_FMT_RAW  = 9'h1ff; // untyped raw code
	localparam logic [8:0]  SFD_FMT_MONO = 9'h18e; // one_bit_monochrome_format
	localparam logic [31:0] SFD_ERR_DATA = 32'h0000_0000; // unmapped read data
	// ----------------------------------------------------------------
	// clear values
	// ----------------------------------------------------------------
	localparam logic clear_value_zero = 1'b0;
	localparam logic clear_value_one  = 1'b1;
	// bus state
	typedef enum logic [0:0] {
		SFD_IDLE = 1'b0,
		SFD_ACK  = 1'b1
	} sfd_bus_e;
endpackage

// ### logic/sfd_top.sv
/*
 surface descriptor upper-field decoder with a wishbone register file.
 assumes classic wishbone single cycles, one clock, synchronous reset.
*/
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sfd_top
	import sfd_pkg::*;
#(
	parameter int ADDR_W = 8 // wishbone byte address width
)(
	input  wire logic              clk_i,          // core clock
	input  wire logic              rst_i,          // sync reset, high
	input  wire logic [ADDR_W-1:0] wb_adr_i,       // byte address
	input  wire logic [31:0]       wb_dat_i,       // write data
	input  wire logic [3:0]        wb_sel_i,       // byte enables
	input  wire logic              wb_we_i,        // write
	input  wire logic              wb_cyc_i,       // cycle
	input  wire logic              wb_stb_i,       // strobe
	output logic      [31:0]       wb_dat_o,       // read data
	output logic                   wb_ack_o,       // ack
	output logic                   append_use_o,   // append counter active
	output logic                   cs_use_o,       // control surface active
	output logic                   cs_pass_o,      // separate control pass
	output logic      [3:0]        clear_sel_o,    // rgba clear selects
	output logic      [11:0]       min_lod_o,      // u4.8 min lod
	output logic      [13:0]       chroma_row_o,   // chroma row offset
	output logic      [31:0]       side_addr_o,    // cs base or append address
	output logic      [8:0]        bits_per_element_o, // bpe of format
	output logic                   fmt_valid_o     // format supported
);
	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (ADDR_W < 5) begin : g_bad_w
		$error("sfd_top: ADDR_W too small for register map");
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [31:0] w5_q, w5_d;     // enables word
	logic [31:0] w6_q, w6_d;     // address word
	logic [31:0] w7_q, w7_d;     // clear / lod word
	logic [9:0]  fmt_q, fmt_d;   // code + compression enable
	logic [3:0]  ctl_q, ctl_d;   // surface kind
	logic [31:0] rd_q, rd_d;     // read data
	sfd_bus_e    bus_q, bus_d;   // ack state
	logic [8:0]  lut_bpe;        // table output
	logic        lut_known;      // table hit
	logic        req;            // fresh request
	logic [7:0]  off;            // low address byte

	assign req = wb_cyc_i && wb_stb_i && (bus_q == SFD_IDLE);
	assign off = 8'(wb_adr_i);

	// byte-lane merge
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// format table
	// ----------------------------------------------------------------
	sfd_bpe_lut u_lut (
		.code_i  (fmt_q[SFD_FMT_W-1:0]),
		.bpe_o   (lut_bpe),
		.known_o (lut_known)
	);

	// ----------------------------------------------------------------
	// decoded view
	// ----------------------------------------------------------------
	logic        two_plane_layout, sampled, rt_or_s, multi, adapt;
	logic        cs_en, app_en, fmt_ok;
	logic [8:0]  bpe_v;
	logic [31:0] side_v;
	logic [3:0]  clr_v;
	logic [11:0] lod_v;
	logic [13:0] chroma_v;
	logic [31:0] status_v;

	// decode of current descriptor
	always_comb begin
		two_plane_layout  = ctl_q[SFD_BIT_TWO_PLANE];
		sampled = ctl_q[SFD_BIT_SAMPLED];
		rt_or_s = ctl_q[SFD_BIT_RT] | sampled;
		multi   = ctl_q[SFD_BIT_MULTI];
		adapt   = fmt_q[SFD_BIT_ADAPT];
		// enable bits only meaningful on non-two_plane_layout words
		cs_en   = !two_plane_layout && rt_or_s && w5_q[SFD_BIT_CS_EN];
		app_en  = !two_plane_layout && !w5_q[SFD_BIT_CS_EN]
			&& w5_q[SFD_BIT_APPEND_EN];
		// other encoding applies when compression set: not decoded here
		fmt_ok  = !adapt && lut_known;
		bpe_v   = fmt_ok ? lut_bpe : 9'h000;
		side_v  = 32'h0000_0000;
		if (cs_en) begin
			side_v = {w6_q[31:SFD_CS_ADDR_LSB], 12'h000};
		end else if (app_en) begin
			side_v = {w6_q[31:SFD_APPEND_LSB], 6'h00};
		end
		chroma_v = two_plane_layout ? w5_q[SFD_CHROMA_MSB:0] : 14'h0000;
		clr_v    = (rt_or_s && multi) ? w7_q[SFD_BIT_CLR_R:SFD_BIT_CLR_A]
			: {4{clear_value_zero}};
		lod_v    = sampled ? w7_q[SFD_LOD_MSB:0] : 12'h000;
		// bpe at 22:14, bits 13:8 spare, flags in 7:0
		status_v = {9'h000, bpe_v, 6'h00, fmt_ok, clr_v, multi && cs_en, cs_en, app_en};
	end

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	// one registered ack per request, a cycle after it, dropped next cycle
	always_comb begin
		w5_d  = w5_q;
		w6_d  = w6_q;
		w7_d  = w7_q;
		fmt_d = fmt_q;
		ctl_d = ctl_q;
		rd_d  = rd_q;
		bus_d = SFD_IDLE;
		if (req) begin
			bus_d = SFD_ACK;
			rd_d  = SFD_ERR_DATA;
			case (off)
				SFD_OFF_WORD5: begin
					rd_d = w5_q;
					if (wb_we_i) w5_d = merge(w5_q, wb_dat_i, wb_sel_i);
				end
				SFD_OFF_WORD6: begin
					rd_d = w6_q;
					if (wb_we_i) w6_d = merge(w6_q, wb_dat_i, wb_sel_i);
				end
				SFD_OFF_WORD7: begin
					rd_d = w7_q;
					if (wb_we_i) w7_d = merge(w7_q, wb_dat_i, wb_sel_i);
				end
				SFD_OFF_FORMAT: begin
					rd_d = {22'h000000, fmt_q};
					if (wb_we_i) fmt_d = 10'(merge({22'h000000, fmt_q}, wb_dat_i, wb_sel_i));
				end
				SFD_OFF_CTRL: begin
					rd_d = {28'h0000000, ctl_q};
					if (wb_we_i && wb_sel_i[0]) ctl_d = wb_dat_i[3:0];
				end
				SFD_OFF_STATUS: rd_d = status_v;
				SFD_OFF_ADDR:   rd_d = side_v;
				default:        rd_d = SFD_ERR_DATA; // unmapped reads zero, writes dropped
			endcase
		end
	end

	// register stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			w5_q  <= SFD_RST_WORD;
			w6_q  <= SFD_RST_WORD;
			w7_q  <= SFD_RST_WORD;
			fmt_q <= 10'h000;
			ctl_q <= 4'h0;
			rd_q  <= SFD_RST_WORD;
			bus_q <= SFD_IDLE;
		end else begin
			w5_q  <= w5_d;
			w6_q  <= w6_d;
			w7_q  <= w7_d;
			fmt_q <= fmt_d;
			ctl_q <= ctl_d;
			rd_q  <= rd_d;
			bus_q <= bus_d;
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	logic        app_q, cs_q, pass_q, fv_q;
	logic [3:0]  clr_q;
	logic [11:0] lod_q;
	logic [13:0] chr_q;
	logic [31:0] side_q;
	logic [8:0]  bpe_q;

	// outputs follow decode one cycle later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			app_q  <= 1'b0;
			cs_q   <= 1'b0;
			pass_q <= 1'b0;
			fv_q   <= 1'b0;
			clr_q  <= 4'h0;
			lod_q  <= 12'h000;
			chr_q  <= 14'h0000;
			side_q <= 32'h0000_0000;
			bpe_q  <= 9'h000;
		end else begin
			app_q  <= app_en;
			cs_q   <= cs_en;
			pass_q <= cs_en && multi && sampled;
			fv_q   <= fmt_ok;
			clr_q  <= clr_v;
			lod_q  <= lod_v;
			chr_q  <= chroma_v;
			side_q <= side_v;
			bpe_q  <= bpe_v;
		end
	end

	assign wb_dat_o           = rd_q;
	assign wb_ack_o           = (bus_q == SFD_ACK);
	assign append_use_o       = app_q;
	assign cs_use_o           = cs_q;
	assign cs_pass_o          = pass_q;
	assign clear_sel_o        = clr_q;
	assign min_lod_o          = lod_q;
	assign chroma_row_o       = chr_q;
	assign side_addr_o        = side_q;
	assign bits_per_element_o = bpe_q;
	assign fmt_valid_o        = fv_q;
endmodule

// ### testbench/sfd_checker.sv
/*
 checker for sfd_top: bus answer timing and relations between decoded outputs.
 assumes sync active-high reset; attached by the bind at the foot of this file.
*/
`timescale 1ns/1ps
module sfd_checker (
	input wire logic        clk_i,              // core clock
	input wire logic        rst_i,              // sync reset
	input wire logic        wb_cyc_i,           // bus cycle
	input wire logic        wb_stb_i,           // bus strobe
	input wire logic        wb_ack_o,           // bus ack
	input wire logic        append_use_o,       // append counter active
	input wire logic        cs_use_o,           // control surface active
	input wire logic        cs_pass_o,          // separate control pass
	input wire logic [31:0] side_addr_o,        // side address
	input wire logic [13:0] chroma_row_o,       // chroma row offset
	input wire logic [8:0]  bits_per_element_o, // format size
	input wire logic        fmt_valid_o         // format supported
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked one cycle later");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_append_addr: assert property (append_use_o |-> !cs_use_o && side_addr_o[5:0] == 6'h00)
		else $error("append address misaligned or clashes with control surface");
	a_cs_base: assert property (cs_use_o |-> side_addr_o[11:0] == 12'h000)
		else $error("control surface base not 4k aligned");
	a_pass_cs: assert property (cs_pass_o |-> cs_use_o)
		else $error("separate pass without control surface");
	a_side_idle: assert property (!cs_use_o && !append_use_o |-> side_addr_o == 32'h0)
		else $error("side address shown while unused");
	a_chroma_plane: assert property (chroma_row_o != 14'h0 |-> !cs_use_o && !append_use_o)
		else $error("chroma offset on a non-two_plane_layout surface");
	a_fmt_bad: assert property (!fmt_valid_o |-> bits_per_element_o == 9'h000)
		else $error("size reported for unsupported format");
	a_side_hold: assert property (!wb_ack_o ##1 !wb_ack_o |-> $stable(side_addr_o))
		else $error("side address changed without a write");
endmodule

bind sfd_top sfd_checker sfd_checker_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.append_use_o, .cs_use_o, .cs_pass_o, .side_addr_o, .chroma_row_o,
	.bits_per_element_o, .fmt_valid_o);

// ### testbench/testbench.sv
/*
 self-checking bench for sfd_top: table of decode and format cases, then bus corners.
 assumes sfd_pkg offsets and a wishbone slave acking one cycle after a request.
*/
`timescale 1ns/1ps
module testbench
	import sfd_pkg::*;
;
	// ------------------------------------------------------------
	// signals and tables
	// ------------------------------------------------------------
	logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i;
	logic        wb_ack_o, append_use_o, cs_use_o, cs_pass_o, fmt_valid_o;
	logic [7:0]  wb_adr_i;
	logic [3:0]  wb_sel_i, clear_sel_o;
	logic [31:0] wb_dat_i, wb_dat_o, side_addr_o, rd;
	logic [11:0] min_lod_o;
	logic [13:0] chroma_row_o;
	logic [8:0]  bits_per_element_o;
	int          fails = 0, tests_run = 0, cycles = 0;
	logic [31:0] dr [6][9]; // w5 w6 w7 ctrl, then flags clr lod chroma side
	logic [9:0]  fc [12];   // format register values
	logic [8:0]  fb [12];   // expected size per format
	logic [11:0] fv;        // expected support per format, row 0 at bit 11

	sfd_top sfd_top_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
		.wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .append_use_o, .cs_use_o,
		.cs_pass_o, .clear_sel_o, .min_lod_o, .chroma_row_o, .side_addr_o,
		.bits_per_element_o, .fmt_valid_o);

	// ------------------------------------------------------------
	// clock, timeout, helpers
	// ------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// hang guard, far above the ~170 cycles the run needs
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			fails++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one classic cycle, held until ack is sampled, then one idle cycle
	task automatic bus(input logic [7:0] a, input logic we, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		wb_adr_i <= a;
		wb_we_i <= we;
		wb_dat_i <= d;
		wb_sel_i <= s;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		@(posedge clk_i);
		while (wb_ack_o !== 1'b1) @(posedge clk_i);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic close_out;
		$display("fails=%0d tests_run=%0d", fails, tests_run);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst_i = 1'b1;
		wb_adr_i = 8'h00;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'h0;
		wb_we_i = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		dr = '{'{32'h2, 32'h12345678, 32'hf0000abc, 32'h0,
				32'h4, 32'h0, 32'h0, 32'h0, 32'h12345640},
			'{32'h3, 32'hfedcba98, 32'ha0000123, 32'ha,
				32'h3, 32'ha, 32'h123, 32'h0, 32'hfedcb000},
			'{32'h2ffe, 32'hffffffff, 32'hffffffff, 32'h5,
				32'h0, 32'h0, 32'h0, 32'h2ffe, 32'h0},
			'{32'h1, 32'hffffffff, 32'h0, 32'h4,
				32'h2, 32'h0, 32'h0, 32'h0, 32'hfffff000},
			'{32'h0, 32'hffffffff, 32'h5fffffff, 32'hc,
				32'h0, 32'h5, 32'h0, 32'h0, 32'h0},
			'{32'h0, 32'h0, 32'hffffffff, 32'h2,
				32'h0, 32'h0, 32'hfff, 32'h0, 32'h0}};
		fc = '{10'h000, 10'h040, 10'h080, 10'h0c0, 10'h100, 10'h140,
			10'h18e, 10'h197, 10'h184, 10'h1ff, 10'h009, 10'h200};
		fb = '{9'h080, 9'h060, 9'h040, 9'h020, 9'h010, 9'h008,
			9'h001, 9'h100, 9'h002, 9'h000, 9'h000, 9'h000};
		fv = 12'hffc;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(side_addr_o, 32'h0);
		// decode rows: write the four words, then compare the flag, clear, lod, chroma and side outputs
		for (int r = 0; r < 6; r++) begin
			for (int k = 0; k < 4; k++)
				bus(k == 3 ? SFD_OFF_CTRL : 8'(k * 4), 1'b1, dr[r][k], 4'hf, rd);
			chk({29'h0, append_use_o, cs_use_o, cs_pass_o}, dr[r][4]);
			chk({28'h0, clear_sel_o}, dr[r][5]);
			chk({20'h0, min_lod_o}, dr[r][6]);
			chk({18'h0, chroma_row_o}, dr[r][7]);
			chk(side_addr_o, dr[r][8]);
		end
		// plain buffer with zero min lod while formats are swept
		bus(SFD_OFF_CTRL, 1'b1, 32'h0, 4'hf, rd);
		bus(SFD_OFF_WORD7, 1'b1, 32'h0, 4'hf, rd);
		// format codes, unlisted code and compression enable
		for (int f = 0; f < 12; f++) begin
			bus(SFD_OFF_FORMAT, 1'b1, {22'h0, fc[f]}, 4'hf, rd);
			chk({22'h0, fmt_valid_o, bits_per_element_o}, {22'h0, fv[11-f], fb[f]});
		end
		// byte lanes merge into a held word; ctrl writes need lane 0
		bus(SFD_OFF_WORD7, 1'b1, 32'h1234_5678, 4'hf, rd);
		bus(SFD_OFF_WORD7, 1'b1, 32'hffff_ffff, 4'h1, rd);
		bus(SFD_OFF_WORD7, 1'b0, 32'h0, 4'hf, rd);
		chk(rd, 32'h1234_56ff);
		bus(SFD_OFF_CTRL, 1'b1, 32'hf, 4'he, rd);
		bus(SFD_OFF_CTRL, 1'b0, 32'h0, 4'hf, rd);
		chk(rd, 32'h0);
		// unmapped place reads zero
		bus(8'h1c, 1'b0, 32'h0, 4'hf, rd);
		chk(rd, 32'h0);
		// format register keeps its ten low bits
		bus(SFD_OFF_FORMAT, 1'b1, 32'hffff_f0c0, 4'hf, rd);
		bus(SFD_OFF_FORMAT, 1'b0, 32'h0, 4'hf, rd);
		chk(rd, 32'h0000_00c0);
		// append address, read-only views, then a reset in mid-run clears it
		bus(SFD_OFF_CTRL, 1'b1, 32'h0, 4'hf, rd);
		bus(SFD_OFF_WORD5, 1'b1, 32'h2, 4'hf, rd);
		bus(SFD_OFF_WORD6, 1'b1, 32'hffff_ffff, 4'hf, rd);
		chk(side_addr_o, 32'hffff_ffc0);
		bus(SFD_OFF_ADDR, 1'b1, 32'hdead_beef, 4'hf, rd);
		bus(SFD_OFF_ADDR, 1'b0, 32'h0, 4'hf, rd);
		chk(rd, 32'hffff_ffc0);
		bus(SFD_OFF_STATUS, 1'b0, 32'h0, 4'hf, rd);
		chk(rd, 32'h0008_0081);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({31'h0, append_use_o}, 32'h0);
		bus(SFD_OFF_WORD6, 1'b0, 32'h0, 4'hf, rd);
		chk(rd, 32'h0);
		chk({22'h0, fmt_valid_o, bits_per_element_o}, 32'h0000_0280);
		close_out();
	end
endmodule
